// File: logic/pair_timer.sv
// Cascaded 16-bit timer: 12-bit PWM duty handling and 16-bit pulse generator
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/100ps

// Contract
// - PWM buffered running: duty commit waits, loads at each 16th overflow.
// - PWM buffered: duty reads return the last written value.
// - PWM buffered stopped: commit loads buffer and active duty together.
// - Unbuffered running write acts at once; lower values wait for overflow.
// - Unbuffered write equal to counter matches immediately, off the tick grid.
// - Unbuffered update during stretch pulse may move edge off grid.
// - Divider codes give gear clock over 2^11,2^10,2^8,2^6,2^4,2^2,2,1.
// - Slow divider or slow mode picks low-frequency clock divisions.
// - Join bit couples channels; lower channel settings are ignored.
// - Pair mode field 11 selects the 16-bit pulse generator.
// - External select 1 counts the external pin instead of the divider.
// - Period and duty are 16-bit values from high and low registers.
// - Writing duty high commits period and duty together.
// - Stopped timer drives the initial level bit on the pulse pin.
// - Running counter steps on source ticks; duty match toggles, first irq.
// - Period match restores initial level, second irq, counter clears.
// - Clearing run stops and clears counter and restores initial level.
// - Shadow buffer enable bit at 1 turns buffering on.
// - Generator buffered running: values load at next period match.
// - Generator buffered stopped: commit loads buffer and active together.
// - Generator unbuffered: values act at once, below waits, equal matches.
// - Generator reads return last written values.
// - PWM: first irq every overflow, second irq every 16th overflow.
// - Stretch bits add one tick in frames 9; 5,13; 3,7,..; even frames.
module pair_timer
	import pair_timer_pkg::*;
(
	input wire logic CLK, // Gear clock, 25 MHz
	input wire logic RESET_N, // Synchronous reset
	input wire logic [7:0] AVS_ADDRESS, // Byte address
	input wire logic AVS_READ, // Read strobe
	input wire logic AVS_WRITE, // Write strobe
	input wire logic [31:0] AVS_WRITEDATA, // Write data
	output logic [31:0] AVS_READDATA, // Read data
	output logic AVS_WAITREQUEST, // Stall
	input wire logic LF_CLK_PIN, // Low-frequency clock, sampled
	input wire logic EXT_COUNT_PIN, // External count clock pin
	output logic PULSE_OUT, // Pulse output pin level
	output logic FIRST_IRQ, // First-channel interrupt pulse
	output logic SECOND_IRQ // Second-channel interrupt pulse
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		regs_t r;
		compare_t buf_v;
		compare_t act;
		logic [15:0] cnt;
		logic out;
		logic hit;
		logic [3:0] frame;
		run_state_t st;
		logic [10:0] pre;
		logic [3:0] lf_pre;
		logic lf_s1, lf_s2, lf_s3;
		logic ex_s1, ex_s2, ex_s3;
		logic irq1, irq2;
		logic wait_n;
		logic wreq;
		logic [31:0] rdata;
	} state_t;

	state_t s_q, s_d;

	logic running, pwm_mode, ppg_mode, dbuf, init_lvl, ext_sel, commit;
	logic lf_edge, ext_edge, int_tick, tick, stretch, duty_match, per_match;
	logic [2:0] div_sel;
	logic [5:0] idx;
	logic [8:0] pwm_cmp;
	logic [3:0] frame_no;
	compare_t wr_v;

	// ------------------------------------------------------------
	// Decoded settings
	// ------------------------------------------------------------
	assign idx = AVS_ADDRESS[7:2];
	assign running = (s_q.st == ST_RUN);
	assign pwm_mode = (s_q.r.mode[MODE_FIELD_LSB +: 2] == PAIR_PWM12);
	assign ppg_mode = (s_q.r.mode[MODE_FIELD_LSB +: 2] == PAIR_PPG16);
	assign dbuf = s_q.r.mode[MODE_DBUF_BIT];
	assign init_lvl = s_q.r.mode[MODE_INIT_BIT];
	assign ext_sel = s_q.r.mode[MODE_EXT_BIT];
	assign div_sel = s_q.r.mode[MODE_DIV_LSB +: 3];
	assign commit = AVS_WRITE && !s_q.wait_n && (idx == IDX_DUTY_HIGH);
	assign wr_v.per = {s_q.r.per_hi, s_q.r.per_lo};
	assign wr_v.duty = {AVS_WRITEDATA[7:0], s_q.r.duty_lo};

	// ------------------------------------------------------------
	// Source clock selection
	// ------------------------------------------------------------
	// Synchronisers rely on the pin holding each level two cycles
	// sampled external clock
	assign ext_edge = s_q.ex_s3 && !s_q.ex_s2;
	assign lf_edge = s_q.lf_s2 && !s_q.lf_s3;

	always_comb begin
		int_tick = 1'b0;
		if (s_q.r.sys[SYS_SLOW_BIT]) begin
			case (div_sel)
				3'h0: int_tick = lf_edge && (s_q.lf_pre == 4'hf);
				3'h1: int_tick = lf_edge && (s_q.lf_pre[2:0] == 3'h7);
				3'h7: int_tick = lf_edge && (s_q.lf_pre[1:0] == 2'h3);
				default: int_tick = 1'b0;
			endcase
		end else begin
			case (div_sel)
				3'h0: int_tick = s_q.r.sys[SYS_DV_BIT] ? lf_edge && (s_q.lf_pre == 4'hf)
					: (s_q.pre == 11'h7ff);
				3'h1: int_tick = s_q.r.sys[SYS_DV_BIT] ? lf_edge && (s_q.lf_pre[2:0] == 3'h7)
					: (s_q.pre[9:0] == 10'h3ff);
				3'h2: int_tick = (s_q.pre[7:0] == 8'hff);
				3'h3: int_tick = (s_q.pre[5:0] == 6'h3f);
				3'h4: int_tick = (s_q.pre[3:0] == 4'hf);
				3'h5: int_tick = (s_q.pre[1:0] == 2'h3);
				3'h6: int_tick = s_q.pre[0];
				default: int_tick = 1'b1;
			endcase
		end
	end

	assign tick = ext_sel ? ext_edge : int_tick;

	// ------------------------------------------------------------
	// Compare logic
	// ------------------------------------------------------------
	assign frame_no = s_q.frame + 4'h1;
	always_comb begin
		stretch = 1'b0;
		if (s_q.act.duty[0] && frame_no == 4'h9) stretch = 1'b1;
		if (s_q.act.duty[1] && frame_no[2:0] == 3'h5) stretch = 1'b1;
		if (s_q.act.duty[2] && frame_no[1:0] == 2'h3) stretch = 1'b1;
		if (s_q.act.duty[3] && !frame_no[0]) stretch = 1'b1;
	end
	assign pwm_cmp = {1'b0, s_q.act.duty[11:4]} + {8'h00, stretch};

	// Compared every clock, so a fresh value equal to the counter hits at once
	// immediate equal match
	assign duty_match = running && !s_q.hit && (pwm_mode ? ({1'b0, s_q.cnt[7:0]} == pwm_cmp)
		: (ppg_mode && s_q.cnt == s_q.act.duty));
	assign per_match = running && tick && (pwm_mode ? (s_q.cnt[7:0] == PWM_TOP)
		: (ppg_mode && s_q.cnt == s_q.act.per));

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.irq1 = 1'b0;
		s_d.irq2 = 1'b0;
		s_d.pre = s_q.pre + 11'h001;
		s_d.lf_s1 = LF_CLK_PIN;
		s_d.lf_s2 = s_q.lf_s1;
		s_d.lf_s3 = s_q.lf_s2;
		s_d.ex_s1 = EXT_COUNT_PIN;
		s_d.ex_s2 = s_q.ex_s1;
		s_d.ex_s3 = s_q.ex_s2;
		if (lf_edge) s_d.lf_pre = s_q.lf_pre + 4'h1;

		// Bus slave: one wait cycle, then answer
		s_d.wait_n = (AVS_READ || AVS_WRITE) && !s_q.wait_n;
		s_d.wreq = !s_d.wait_n;
		if ((AVS_READ || AVS_WRITE) && !s_q.wait_n) begin
			case (idx)
				IDX_DUTY_LOW: s_d.rdata = {24'h000000, s_q.r.duty_lo};
				IDX_DUTY_HIGH: s_d.rdata = {24'h000000, s_q.r.duty_hi};
				IDX_PERIOD_LOW: s_d.rdata = {24'h000000, s_q.r.per_lo};
				IDX_PERIOD_HIGH: s_d.rdata = {24'h000000, s_q.r.per_hi};
				IDX_PAIR_MODE: s_d.rdata = {24'h000000, s_q.r.mode};
				IDX_PAIR_CONTROL: s_d.rdata = {29'h00000000, s_q.r.ctrl};
				IDX_SYS_CONTROL: s_d.rdata = {30'h00000000, s_q.r.sys};
				IDX_STATUS: s_d.rdata = {10'h000, s_q.frame, running, s_q.out, s_q.cnt};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		if (AVS_WRITE && !s_q.wait_n) begin
			case (idx)
				IDX_DUTY_LOW: s_d.r.duty_lo = AVS_WRITEDATA[7:0];
				IDX_DUTY_HIGH: s_d.r.duty_hi = AVS_WRITEDATA[7:0];
				IDX_PERIOD_LOW: s_d.r.per_lo = AVS_WRITEDATA[7:0];
				IDX_PERIOD_HIGH: s_d.r.per_hi = AVS_WRITEDATA[7:0];
				// Mode is frozen while counting so settings cannot tear a frame
				IDX_PAIR_MODE: if (!running) s_d.r.mode = AVS_WRITEDATA[7:0];
				IDX_PAIR_CONTROL: s_d.r.ctrl = AVS_WRITEDATA[2:0];
				IDX_SYS_CONTROL: s_d.r.sys = AVS_WRITEDATA[1:0];
				default: ;
			endcase
		end

		if (commit) begin
			s_d.buf_v = wr_v;
			if (!dbuf || !running) begin
				if (pwm_mode) s_d.act.duty = wr_v.duty;
				else s_d.act = wr_v;
			end
		end

		case (s_q.st)
			ST_STOP: begin
				s_d.out = init_lvl;
				s_d.cnt = 16'h0000;
				s_d.hit = 1'b0;
				s_d.frame = 4'h0;
				if (s_q.r.ctrl[CTRL_RUN_BIT] && s_q.r.ctrl[CTRL_JOIN_BIT]) s_d.st = ST_RUN;
			end
			ST_RUN: begin
				if (duty_match) begin
					s_d.out = !init_lvl;
					s_d.hit = 1'b1;
					if (ppg_mode) s_d.irq1 = 1'b1;
				end
				if (tick) s_d.cnt = s_q.cnt + 16'h0001;
				if (per_match) begin
					s_d.out = init_lvl;
					s_d.hit = 1'b0;
					s_d.cnt = 16'h0000;
					if (ppg_mode) begin
						s_d.irq2 = 1'b1;
						if (dbuf) s_d.act = commit ? wr_v : s_q.buf_v;
					end else begin
						s_d.irq1 = 1'b1;
						s_d.frame = s_q.frame + 4'h1;
						if (s_q.frame == FRAME_LAST) begin
							s_d.irq2 = 1'b1;
							if (dbuf) s_d.act.duty = commit ? wr_v.duty : s_q.buf_v.duty;
						end
					end
				end
				if (!s_q.r.ctrl[CTRL_RUN_BIT] || !s_q.r.ctrl[CTRL_JOIN_BIT]) begin
					s_d.st = ST_STOP;
					s_d.cnt = 16'h0000;
					s_d.out = init_lvl;
					s_d.hit = 1'b0;
					s_d.frame = 4'h0;
				end
			end
			default: s_d.st = ST_STOP;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			s_q <= '0;
			s_q.r.duty_lo <= TIMER_REG_RESET;
			s_q.r.duty_hi <= TIMER_REG_RESET;
			s_q.r.per_lo <= TIMER_REG_RESET;
			s_q.r.per_hi <= TIMER_REG_RESET;
			s_q.r.mode <= MODE_RESET;
			s_q.buf_v <= '1;
			s_q.act <= '1;
			s_q.st <= ST_STOP;
			s_q.wreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign AVS_READDATA = s_q.rdata;
	assign AVS_WAITREQUEST = s_q.wreq;
	assign PULSE_OUT = s_q.out;
	assign FIRST_IRQ = s_q.irq1;
	assign SECOND_IRQ = s_q.irq2;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_stop_clear;
		@(posedge CLK) disable iff (!RESET_N)
		(running && !s_q.r.ctrl[CTRL_RUN_BIT]) |=> (s_q.cnt == 16'h0000) && !running
			&& (PULSE_OUT == $past(init_lvl));
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear");

	property p_idle_level;
		@(posedge CLK) disable iff (!RESET_N)
		(!running && !$past(running) && $stable(init_lvl)) |-> (PULSE_OUT == init_lvl);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

	property p_ppg_buffered;
		@(posedge CLK) disable iff (!RESET_N)
		(commit && ppg_mode && dbuf && running && !per_match) |=> $stable(s_q.act);
	endproperty
	a_ppg_buffered: assert property (p_ppg_buffered) else $error("buffer leaked");

	property p_ppg_stopped_load;
		@(posedge CLK) disable iff (!RESET_N)
		(commit && ppg_mode && !running) |=> (s_q.act == s_q.buf_v) && (s_q.act == $past(wr_v));
	endproperty
	a_ppg_stopped_load: assert property (p_ppg_stopped_load) else $error("no load");

	property p_period_match;
		@(posedge CLK) disable iff (!RESET_N)
		(per_match && ppg_mode && s_q.r.ctrl[CTRL_RUN_BIT] && s_q.r.ctrl[CTRL_JOIN_BIT])
			|=> SECOND_IRQ && (s_q.cnt == 16'h0000) && (PULSE_OUT == $past(init_lvl));
	endproperty
	a_period_match: assert property (p_period_match) else $error("period match");

	property p_duty_toggle;
		@(posedge CLK) disable iff (!RESET_N)
		(duty_match && ppg_mode && !per_match && s_q.r.ctrl[CTRL_RUN_BIT]
			&& s_q.r.ctrl[CTRL_JOIN_BIT]) |=> FIRST_IRQ && (PULSE_OUT != init_lvl);
	endproperty
	a_duty_toggle: assert property (p_duty_toggle) else $error("duty toggle");

	property p_pwm_frames;
		@(posedge CLK) disable iff (!RESET_N)
		(per_match && pwm_mode && s_q.r.ctrl[CTRL_RUN_BIT] && s_q.r.ctrl[CTRL_JOIN_BIT])
			|=> FIRST_IRQ && (SECOND_IRQ == ($past(s_q.frame) == FRAME_LAST));
	endproperty
	a_pwm_frames: assert property (p_pwm_frames) else $error("overflow irq");

	property p_pwm_buffered;
		@(posedge CLK) disable iff (!RESET_N)
		(commit && pwm_mode && dbuf && running && !(per_match && s_q.frame == FRAME_LAST))
			|=> $stable(s_q.act.duty) ##1 (s_q.buf_v.duty == $past(s_q.buf_v.duty));
	endproperty
	a_pwm_buffered: assert property (p_pwm_buffered) else $error("duty leaked");

	property p_bus_answer;
		@(posedge CLK) disable iff (!RESET_N)
		(AVS_READ && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
endmodule : pair_timer

// File: logic/pair_timer_pkg.sv
// Shared constants and types for the cascaded timer pulse block
package pair_timer_pkg;
	// ------------------------------------------------------------
	// Register word indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_DUTY_LOW = 6'h28;
	localparam logic [5:0] IDX_DUTY_HIGH = 6'h29;
	localparam logic [5:0] IDX_PERIOD_LOW = 6'h2a;
	localparam logic [5:0] IDX_PERIOD_HIGH = 6'h2b;
	localparam logic [5:0] IDX_PAIR_MODE = 6'h2c;
	localparam logic [5:0] IDX_PAIR_CONTROL = 6'h2d;
	localparam logic [5:0] IDX_SYS_CONTROL = 6'h2e;
	localparam logic [5:0] IDX_STATUS = 6'h2f;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_FIELD_LSB = 0;
	localparam int MODE_DIV_LSB = 2;
	localparam int MODE_EXT_BIT = 5;
	localparam int MODE_INIT_BIT = 6;
	localparam int MODE_DBUF_BIT = 7;
	localparam int CTRL_JOIN_BIT = 0;
	localparam int CTRL_LRUN_BIT = 1;
	localparam int CTRL_RUN_BIT = 2;
	localparam int SYS_DV_BIT = 0;
	localparam int SYS_SLOW_BIT = 1;

	// ------------------------------------------------------------
	// Encodings and values after reset
	// ------------------------------------------------------------
	localparam logic [1:0] PAIR_PWM12 = 2'h2;
	localparam logic [1:0] PAIR_PPG16 = 2'h3;
	localparam logic [7:0] TIMER_REG_RESET = 8'hff;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [3:0] FRAME_LAST = 4'hf;
	localparam logic [7:0] PWM_TOP = 8'hff;

	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01
	} run_state_t;

	typedef struct packed {
		logic [7:0] duty_lo;
		logic [7:0] duty_hi;
		logic [7:0] per_lo;
		logic [7:0] per_hi;
		logic [7:0] mode;
		logic [2:0] ctrl;
		logic [1:0] sys;
	} regs_t;

	typedef struct packed {
		logic [15:0] per;
		logic [15:0] duty;
	} compare_t;
endpackage : pair_timer_pkg

// File: bench/pulse_load.sv
// Far-side model: load on the pulse pin and source of the external count clock
`timescale 1ns/100ps
module pulse_load (
	input wire logic clk, // Gear clock
	input wire logic ext_run, // Lets the count clock run
	input wire logic pulse_in, // Pulse pin as seen by the load
	output logic ext_clk, // External count clock
	output int rise_count // Rising edges seen on the pulse pin
);
	logic [1:0] div_q;
	logic pulse_q;

	initial begin
		div_q = 2'h0;
		ext_clk = 1'b0;
		pulse_q = 1'b0;
		rise_count = 0;
	end

	// four gear cycles high and low, well under half the gear rate
	always @(posedge clk) begin
		div_q <= ext_run ? div_q + 2'h1 : 2'h0;
		ext_clk <= ext_run ? (div_q == 2'h3 ? ~ext_clk : ext_clk) : 1'b0;
	end

	always @(posedge clk) begin
		pulse_q <= pulse_in;
		if (pulse_in && !pulse_q) begin
			rise_count <= rise_count + 1;
		end
	end
endmodule : pulse_load

// File: bench/testbench.sv
// Self-checking bench for the cascaded timer pulse block
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	import pair_timer_pkg::*;
	logic clk, reset_n, avs_read, avs_write, lf_clk, ext_run, ext_clk;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic avs_waitrequest, pulse_out, first_irq, second_irq;
	logic [2:0] lf_div, code;
	int rises, miscompares, tests_run, cycles, c, r0;
	int divs[8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};

	pair_timer pair_timer_i (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.LF_CLK_PIN(lf_clk), .EXT_COUNT_PIN(ext_clk), .PULSE_OUT(pulse_out),
		.FIRST_IRQ(first_irq), .SECOND_IRQ(second_irq));
	pulse_load pulse_load_i (.clk(clk), .ext_run(ext_run), .pulse_in(pulse_out),
		.ext_clk(ext_clk), .rise_count(rises));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Low-frequency clock of eight gear cycles keeps expectations exact
	always @(posedge clk) begin
		lf_div <= lf_div + 3'h1;
		lf_clk <= lf_div[2];
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			miscompares++;
			results();
		end
	end

	task results();
		if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results

	// Waits for the answer however long it takes; only the cycle ceiling ends a hang
	task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task wait_irq(input logic second, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((second ? second_irq : first_irq) !== 1'b1 && n < 40000);
		if (n >= 40000) begin
			miscompares++;
			$display("mismatch at %0t: interrupt missing", $time);
		end
	endtask : wait_irq

	// Cycles of high pulse level up to and including the next overflow interrupt
	task high_time(output int h);
		h = 0;
		do begin
			@(posedge clk);
			h += int'(pulse_out === 1'b1);
		end while (first_irq !== 1'b1);
	endtask : high_time

	task commit(input logic [15:0] per, input logic [15:0] duty);
		bus(1'b1, IDX_PERIOD_LOW, per[7:0]);
		bus(1'b1, IDX_PERIOD_HIGH, per[15:8]);
		bus(1'b1, IDX_DUTY_LOW, duty[7:0]);
		bus(1'b1, IDX_DUTY_HIGH, duty[15:8]);
	endtask : commit

	// Stop, load mode and values, then start with join and run set
	task setup(input logic [7:0] mode, input logic [15:0] per, input logic [15:0] duty);
		bus(1'b1, IDX_PAIR_CONTROL, 8'h01);
		bus(1'b1, IDX_PAIR_MODE, mode);
		commit(per, duty);
		bus(1'b1, IDX_PAIR_CONTROL, 8'h05);
	endtask : setup

	task s_reset();
		bus(1'b0, IDX_DUTY_LOW, 8'h00);
		`CHK(rd[7:0], TIMER_REG_RESET)
		bus(1'b0, IDX_PAIR_MODE, 8'h00);
		`CHK(rd[7:0], MODE_RESET)
		bus(1'b0, 6'h00, 8'h00);
		`CHK(rd, 32'h0)
	endtask : s_reset

	task s_walk(input logic init);
		setup({1'b0, init, 6'h1f}, 16'h0003, 16'h0001);
		wait_irq(1'b0, c);
		`CHK(pulse_out, ~init)
		wait_irq(1'b1, c);
		`CHK(c, 2)
		`CHK(pulse_out, init)
		r0 = rises;
		wait_irq(1'b1, c);
		`CHK(c, 4)
		`CHK(rises - r0, 1)
		bus(1'b1, IDX_PAIR_CONTROL, 8'h01);
		bus(1'b0, IDX_STATUS, 8'h00);
		`CHK(rd[15:0], 16'h0000)
		`CHK(pulse_out, init)
		bus(1'b1, IDX_PAIR_MODE, {1'b0, ~init, 6'h1f});
		repeat (2) @(posedge clk);
		`CHK(pulse_out, ~init)
	endtask : s_walk

	task s_div();
		for (int i = 0; i < 8; i++) begin
			code = 3'(i);
			setup({3'b000, code, 2'b11}, 16'h0003, 16'h0001);
			wait_irq(1'b1, c);
			wait_irq(1'b1, c);
			`CHK(c, 4 * divs[i])
		end
	endtask : s_div

	task s_slow();
		logic [1:0] sysv[3] = '{2'h1, 2'h1, 2'h2};
		logic [2:0] codes[3] = '{3'h0, 3'h1, 3'h7};
		int exp[3] = '{512, 256, 128};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, IDX_SYS_CONTROL, {6'h0, sysv[i]});
			setup({3'b000, codes[i], 2'b11}, 16'h0003, 16'h0001);
			wait_irq(1'b1, c);
			wait_irq(1'b1, c);
			`CHK(c, exp[i])
		end
		bus(1'b1, IDX_SYS_CONTROL, 8'h00);
	endtask : s_slow

	task s_ext();
		ext_run <= 1'b1;
		setup(8'h3f, 16'h0003, 16'h0001);
		wait_irq(1'b1, c);
		wait_irq(1'b1, c);
		`CHK(c, 32)
		ext_run <= 1'b0;
	endtask : s_ext

	// New period lies above the counter: unbuffered acts now, buffered waits for match
	task s_update(input logic buffered);
		setup({buffered, 7'h1f}, 16'h00ff, 16'h0001);
		wait_irq(1'b1, c);
		`CHK(c < 300, 1'b1)
		commit(16'h0040, 16'h0002);
		wait_irq(1'b1, c);
		`CHK(c > 200, buffered)
		wait_irq(1'b1, c);
		`CHK(c, 65)
		bus(1'b0, IDX_DUTY_LOW, 8'h00);
		`CHK(rd[7:0], 8'h02)
	endtask : s_update

	task s_pwm();
		setup(8'h9e, 16'h0000, 16'h0100);
		wait_irq(1'b0, c);
		wait_irq(1'b0, c);
		`CHK(c, 256)
		wait_irq(1'b1, c);
		commit(16'h0000, 16'h0123);
		bus(1'b0, IDX_DUTY_LOW, 8'h00);
		`CHK(rd[7:0], 8'h23)
		wait_irq(1'b1, c);
		wait_irq(1'b1, c);
		`CHK(c, 4096)
	endtask : s_pwm

	// Compare 16, stretch on even frames: two frames high 238 and 239 cycles
	task s_stretch();
		int h1, h2;
		setup(8'h1e, 16'h0000, 16'h0108);
		wait_irq(1'b0, c);
		high_time(h1);
		high_time(h2);
		`CHK(h1 + h2, 477)
	endtask : s_stretch

	initial begin
		reset_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		ext_run = 1'b0;
		lf_clk = 1'b0;
		lf_div = 3'h0;
		cycles = 0;
		miscompares = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		s_reset();
		s_walk(1'b0);
		s_walk(1'b1);
		s_div();
		s_slow();
		s_ext();
		s_update(1'b0);
		s_update(1'b1);
		s_pwm();
		s_stretch();
		results();
	end
endmodule : testbench
